// >>> logic/cgdc_pkg.sv
// constants, register layouts and carriers of the clock gate and divider control block
// What this block does
// R1: gate bits 20..4 pass peripheral clocks, reset set
// R2: timekeeping counter runs regardless of its gate
// R3: gate bit 3 requests sleep, resets zero
// R4: idle bit stays until software clears it
// R5: usb clock off stops usb pll; on inserts lock
// R6: main pll powers down only in slow mode
// R7: software waits 300 us before leaving slow mode
// R8: fast clock is pll or input over twice divider
// R9: usb clock halve selects pll or pll over two
// R10: software sets halve to get 48 MHz usb clock
// R11: bus divider codes 00, 01 divide by 1, 2
// R12: code 10 divides by four or eight
// R13: code 11 divides by three or six
// R14: peripheral clock is bus clock or its half
// R15: voltage scaling moves core onto bus clock
// R16: camera select picks raw or divided usb pll
// R17: camera divides usb pll by twice the field plus two
// R18: idle entered only after processor acknowledge
// R19: clock changes switch without glitches or runts
package cgdc_pkg;
   localparam logic [31:0] CGDC_GATE_ADDR = 32'h4C00000C;
   localparam logic [31:0] CGDC_SLOW_ADDR = 32'h4C000010;
   localparam logic [31:0] CGDC_DIV_ADDR = 32'h4C000014;
   localparam logic [31:0] CGDC_CAM_ADDR = 32'h4C000018;
   localparam logic [31:0] CGDC_STAT_ADDR = 32'h4C00001C;

   localparam logic [31:0] CGDC_GATE_RESET = 32'h00FFFFF0;
   localparam logic [31:0] CGDC_SLOW_RESET = 32'h00000004;
   localparam logic [31:0] CGDC_DIV_RESET = 32'h00000000;
   localparam logic [31:0] CGDC_CAM_RESET = 32'h00000000;

   // writable bits of each register; everything else reads zero
   localparam logic [31:0] CGDC_GATE_MASK = 32'h001FFFFC;
   localparam logic [31:0] CGDC_SLOW_MASK = 32'h000000B7;
   localparam logic [31:0] CGDC_DIV_MASK = 32'h0000000F;
   localparam logic [31:0] CGDC_CAM_MASK = 32'h0000131F;

   localparam int CGDC_GATE_HI = 20;
   localparam int CGDC_GATE_LO = 4;
   localparam int CGDC_RTC_BIT = 14;
   localparam int CGDC_SLEEP_BIT = 3;
   localparam int CGDC_IDLE_BIT = 2;
   localparam int CGDC_USB_OFF_BIT = 7;
   localparam int CGDC_PLL_DOWN_BIT = 5;
   localparam int CGDC_SLOW_BIT = 4;
   localparam int CGDC_SLOW_DIV_LO = 0;
   localparam int CGDC_HALVE_BIT = 3;
   localparam int CGDC_SYSDIV_LO = 1;
   localparam int CGDC_PDIV_BIT = 0;
   localparam int CGDC_VSCALE_BIT = 12;
   localparam int CGDC_Q_HALVE_BIT = 9;
   localparam int CGDC_T_HALVE_BIT = 8;
   localparam int CGDC_CAM_SEL_BIT = 4;
   localparam int CGDC_CAM_DIV_LO = 0;
   // status register bits
   localparam int CGDC_ST_PLL_DOWN = 0;
   localparam int CGDC_ST_PLL_SETTLED = 1;
   localparam int CGDC_ST_USB_LOCKED = 2;
   localparam int CGDC_ST_IDLE = 3;

   // peripherals on the system bus clock, the rest on the peripheral clock
   localparam logic [20:4] CGDC_ON_SYS_BUS = 17'b0_1000_0000_0000_0111;

   localparam int CGDC_CLK_PERIOD_NS = 10;
   localparam int CGDC_SETTLE_TIME_US = 300;
   localparam int CGDC_SETTLE_CYCLES = CGDC_SETTLE_TIME_US * 1000 / CGDC_CLK_PERIOD_NS;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cgdc_bus_req_type;

   // one-cycle rate enables of the clock sources
   typedef struct packed {
      logic main_pll;
      logic usb_pll;
      logic input_clk;
   } cgdc_source_type;

   // one-cycle rate enables of the generated clocks
   typedef struct packed {
      logic core_fast_clock;
      logic core;
      logic system_bus;
      logic peripheral_bus;
      logic usb_clock;
      logic camera_clock;
      logic rtc_count;
   } cgdc_clocks_type;
endpackage

// >>> logic/cgdc_top.sv
// clock gate and divider control: registers, dividers, gates and power requests
`timescale 1ns/1ns
`default_nettype none
module cgdc_top #(
   parameter int SETTLE_CYCLES = cgdc_pkg::CGDC_SETTLE_CYCLES,
   parameter int USB_LOCK_CYCLES = cgdc_pkg::CGDC_SETTLE_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // register port
   input wire cgdc_pkg::cgdc_bus_req_type bus_req,
   output logic [31:0] rdata,
   // clock sources as rate enables
   input wire cgdc_pkg::cgdc_source_type source,
   // generated clock enables
   output cgdc_pkg::cgdc_clocks_type clocks,
   output logic [20:4] gated_clk_en,
   // power control
   output logic main_pll_power_down,
   output logic usb_pll_power_down,
   output logic sleep_request,
   output logic idle_request,
   input wire logic cpu_idle_ack,
   output logic idle_active
);
   import cgdc_pkg::*;

   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_chk_settle
      $error("SETTLE_CYCLES out of range");
   end
   if (USB_LOCK_CYCLES < 1 || USB_LOCK_CYCLES > 65535) begin : g_chk_lock
      $error("USB_LOCK_CYCLES out of range");
   end

   logic [31:0] clock_gate_control;
   logic [31:0] slow_clock_control;
   logic [31:0] clock_divider_control;
   logic [31:0] camera_divider_control;
   logic [31:0] status;

   // divider counters and the ratios latched at each wrap, then the pll settle and usb lock timers
   logic [3:0] fast_cnt, fast_ratio;
   logic [2:0] sys_cnt, sys_ratio;
   logic pcnt, pratio;
   logic ucnt, uratio;
   logic [4:0] cam_cnt, cam_ratio;
   logic [15:0] settle_cnt, lock_cnt;
   logic pll_settled, usb_locked;

   logic next_fast, next_sys, next_per, next_usb, next_cam;
   logic slow_mode, pll_down;
   logic [2:0] slow_divider;
   logic [3:0] camera_divide_field;

   // wrap test shared by the fast, bus and camera dividers; >= keeps a shrunk ratio from overrunning
   function automatic logic div_wrap(input logic [4:0] cnt, input logic [4:0] ratio);
      return cnt >= ratio - 5'h01;
   endfunction

   function automatic logic [2:0] sys_bus_ratio(input logic [1:0] code, input logic q,
                                                input logic t);
      unique case (code)
         2'b00: return 3'h1; // [R11]
         2'b01: return 3'h2; // [R11]
         2'b10: return q ? 3'h0 : 3'h4; // [R12] eight coded as zero
         2'b11: return t ? 3'h6 : 3'h3; // [R13]
      endcase
   endfunction

   assign slow_mode = slow_clock_control[CGDC_SLOW_BIT];
   assign slow_divider = slow_clock_control[CGDC_SLOW_DIV_LO +: 3];
   assign camera_divide_field = camera_divider_control[CGDC_CAM_DIV_LO +: 4];
   assign pll_down = slow_mode & slow_clock_control[CGDC_PLL_DOWN_BIT]; // [R6]

   // register writes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         // bits above the gate field are dropped so the reset value reads back as written
         clock_gate_control <= CGDC_GATE_RESET & CGDC_GATE_MASK; // [R1] [R3] [R4]
         slow_clock_control <= CGDC_SLOW_RESET;
         clock_divider_control <= CGDC_DIV_RESET;
         camera_divider_control <= CGDC_CAM_RESET;
      end else if (bus_req.wr) begin
         // idle and sleep bits change only here, never by hardware [R4]
         unique case (bus_req.addr)
            CGDC_GATE_ADDR: clock_gate_control <= bus_req.wdata & CGDC_GATE_MASK;
            CGDC_SLOW_ADDR: slow_clock_control <= bus_req.wdata & CGDC_SLOW_MASK;
            CGDC_DIV_ADDR: clock_divider_control <= bus_req.wdata & CGDC_DIV_MASK;
            CGDC_CAM_ADDR: camera_divider_control <= bus_req.wdata & CGDC_CAM_MASK;
            default: ;
         endcase
      end
   end

   always_comb begin
      status = 32'h00000000;
      status[CGDC_ST_PLL_DOWN] = main_pll_power_down;
      status[CGDC_ST_PLL_SETTLED] = pll_settled;
      status[CGDC_ST_USB_LOCKED] = usb_locked;
      status[CGDC_ST_IDLE] = idle_active;
   end

   // register reads, data in the cycle after the strobe only
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 32'h00000000;
      end else if (bus_req.rd) begin
         unique case (bus_req.addr)
            CGDC_GATE_ADDR: rdata <= clock_gate_control;
            CGDC_SLOW_ADDR: rdata <= slow_clock_control;
            CGDC_DIV_ADDR: rdata <= clock_divider_control;
            CGDC_CAM_ADDR: rdata <= camera_divider_control;
            CGDC_STAT_ADDR: rdata <= status;
            default: rdata <= 32'h00000000;
         endcase
      end else begin
         rdata <= 32'h00000000;
      end
   end

   // main pll power and settle timer; software polls settled before leaving slow mode
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         main_pll_power_down <= 1'b0;
         settle_cnt <= 16'h0000;
         pll_settled <= 1'b0;
      end else begin
         main_pll_power_down <= pll_down; // [R6]
         if (pll_down) begin
            settle_cnt <= 16'h0000;
            pll_settled <= 1'b0;
         end else if (settle_cnt == 16'(SETTLE_CYCLES - 1)) begin
            pll_settled <= 1'b1; // [R7]
         end else begin
            settle_cnt <= settle_cnt + 16'h0001;
         end
      end
   end

   // usb pll power and automatic lock delay
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         usb_pll_power_down <= 1'b0;
         lock_cnt <= 16'h0000;
         usb_locked <= 1'b0;
      end else begin
         usb_pll_power_down <= slow_clock_control[CGDC_USB_OFF_BIT]; // [R5]
         if (slow_clock_control[CGDC_USB_OFF_BIT]) begin
            lock_cnt <= 16'h0000;
            usb_locked <= 1'b0;
         end else if (lock_cnt == 16'(USB_LOCK_CYCLES - 1)) begin
            usb_locked <= 1'b1; // [R5]
         end else begin
            lock_cnt <= lock_cnt + 16'h0001;
         end
      end
   end

   // fast clock: in slow mode the ratio is taken only at a wrap so no runt pulse appears
   always_comb begin
      if (!slow_mode) begin
         next_fast = source.main_pll & ~main_pll_power_down; // [R8]
      end else begin
         next_fast = source.input_clk & div_wrap({1'b0, fast_cnt}, {1'b0, fast_ratio}); // [R8]
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fast_cnt <= 4'h0;
         fast_ratio <= 4'h1;
      end else if (slow_mode && source.input_clk) begin
         if (div_wrap({1'b0, fast_cnt}, {1'b0, fast_ratio})) begin
            fast_cnt <= 4'h0;
            fast_ratio <= (slow_divider == 3'h0) ? 4'h1 : {slow_divider, 1'b0}; // [R8] [R19]
         end else begin
            fast_cnt <= fast_cnt + 4'h1;
         end
      end else if (!slow_mode) begin
         fast_cnt <= 4'h0;
         fast_ratio <= (slow_divider == 3'h0) ? 4'h1 : {slow_divider, 1'b0};
      end
   end

   // system bus divider follows the fast clock pulses, the peripheral divider the bus pulses
   assign next_sys = next_fast &
      div_wrap({2'b00, sys_cnt}, (sys_ratio == 3'h0) ? 5'h08 : {2'b00, sys_ratio});
   assign next_per = next_sys & (pcnt == pratio); // [R14]

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sys_cnt <= 3'h0;
         sys_ratio <= 3'h1;
      end else if (next_fast) begin
         if (next_sys) begin
            sys_cnt <= 3'h0;
            sys_ratio <= sys_bus_ratio(clock_divider_control[CGDC_SYSDIV_LO +: 2],
               camera_divider_control[CGDC_Q_HALVE_BIT],
               camera_divider_control[CGDC_T_HALVE_BIT]); // [R19]
         end else begin
            sys_cnt <= sys_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pcnt <= 1'b0;
         pratio <= 1'b0;
      end else if (next_sys) begin
         if (pcnt == pratio) begin
            pcnt <= 1'b0;
            pratio <= clock_divider_control[CGDC_PDIV_BIT]; // [R14] [R19]
         end else begin
            pcnt <= 1'b1;
         end
      end
   end

   // usb clock: held off until the usb pll has locked
   assign next_usb = source.usb_pll & usb_locked & (ucnt == uratio); // [R5] [R9]

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ucnt <= 1'b0;
         uratio <= 1'b0;
      end else if (source.usb_pll) begin
         if (ucnt == uratio) begin
            ucnt <= 1'b0;
            uratio <= clock_divider_control[CGDC_HALVE_BIT]; // [R9] [R19]
         end else begin
            ucnt <= 1'b1;
         end
      end
   end

   // camera clock from the usb pll, raw or divided
   always_comb begin
      if (!camera_divider_control[CGDC_CAM_SEL_BIT]) begin
         next_cam = source.usb_pll & usb_locked; // [R16]
      end else begin
         next_cam = source.usb_pll & usb_locked & div_wrap(cam_cnt, cam_ratio); // [R17]
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cam_cnt <= 5'h00;
         cam_ratio <= 5'h02;
      end else if (source.usb_pll) begin
         if (div_wrap(cam_cnt, cam_ratio)) begin
            cam_cnt <= 5'h00;
            cam_ratio <= {camera_divide_field + 4'h1, 1'b0}; // [R17] [R19]
         end else begin
            cam_cnt <= cam_cnt + 5'h01;
         end
      end
   end

   // registered clock enables and peripheral gates
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         clocks <= '0;
         gated_clk_en <= '0;
      end else begin
         clocks.core_fast_clock <= next_fast;
         clocks.core <= camera_divider_control[CGDC_VSCALE_BIT] ? next_sys : next_fast; // [R15]
         clocks.system_bus <= next_sys;
         clocks.peripheral_bus <= next_per;
         clocks.usb_clock <= next_usb;
         clocks.camera_clock <= next_cam;
         clocks.rtc_count <= source.input_clk; // [R2]
         for (int i = CGDC_GATE_LO; i <= CGDC_GATE_HI; i++) begin
            // a gate only masks whole pulses, so no partial pulse can leak [R1] [R19]
            gated_clk_en[i] <= clock_gate_control[i] & (CGDC_ON_SYS_BUS[i] ? next_sys : next_per);
         end
      end
   end

   // sleep and idle requests
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sleep_request <= 1'b0;
         idle_request <= 1'b0;
         idle_active <= 1'b0;
      end else begin
         sleep_request <= clock_gate_control[CGDC_SLEEP_BIT]; // [R3]
         idle_request <= clock_gate_control[CGDC_IDLE_BIT]; // [R4]
         if (!clock_gate_control[CGDC_IDLE_BIT]) begin
            idle_active <= 1'b0;
         end else if (idle_request && cpu_idle_ack) begin
            idle_active <= 1'b1; // [R18]
         end
      end
   end

   pll_down_slow_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
      main_pll_power_down |-> $past(slow_mode))
      else $error("main pll powered down outside slow mode");
   pll_down_follow_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
      pll_down |=> main_pll_power_down)
      else $error("main pll not powered down in slow mode");
   idle_ack_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R18]
      $rose(idle_active) |-> $past(cpu_idle_ack) && $past(idle_request))
      else $error("idle entered without acknowledge");
   idle_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
      $fell(clock_gate_control[CGDC_IDLE_BIT]) |-> $past(bus_req.wr))
      else $error("idle bit cleared by hardware");
   usb_off_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
      slow_clock_control[CGDC_USB_OFF_BIT] |=> usb_pll_power_down ##1 !clocks.usb_clock)
      else $error("usb clock running while off");
   fast_norm_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R8]
      !slow_mode && !main_pll_power_down |-> (next_fast == source.main_pll))
      else $error("fast clock not following main pll");
   rtc_run_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R2]
      source.input_clk |=> clocks.rtc_count)
      else $error("timekeeping clock stopped");
   gate_off_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
      !clock_gate_control[CGDC_RTC_BIT] |=> !gated_clk_en[CGDC_RTC_BIT])
      else $error("gated clock passed while disabled");
   per_half_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R14]
      next_per |-> next_sys)
      else $error("peripheral pulse without bus pulse");
   sleep_out_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
      clock_gate_control[CGDC_SLEEP_BIT] |=> sleep_request)
      else $error("sleep request not raised");
endmodule
`default_nettype wire

// >>> verif/cgdc_tb.sv
// self-checking testbench of the clock gate and divider control block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import cgdc_pkg::*;
   localparam int FAST = 6;
   localparam int CORE = 5;
   localparam int BUS = 4;
   localparam int PER = 3;
   localparam int USB = 2;
   localparam int CAM = 1;
   localparam int RTC = 0;
   logic mclk;
   logic reset_n;
   cgdc_bus_req_type bus_req;
   logic [31:0] rdata;
   cgdc_source_type source;
   cgdc_clocks_type clocks;
   logic [20:4] gated_clk_en;
   logic main_pll_power_down;
   logic usb_pll_power_down;
   logic sleep_request;
   logic idle_request;
   logic cpu_idle_ack;
   logic idle_active;
   int fails;
   int total_checks;
   int gap;
   logic [31:0] rd_val;
   logic [20:4] seen;
   logic [31:0] pat [2] = '{32'h000AAAA0, 32'h00155550};
   int div_tab [7] = '{0, 2, 4, 4, 6, 6, 3};
   int cam_tab [7] = '{0, 0, 0, 'h200, 0, 'h100, 'h1000};
   int bus_tab [7] = '{1, 2, 4, 8, 3, 6, 2};
   int per_tab [7] = '{1, 2, 4, 8, 3, 6, 4};
   int core_tab [7] = '{1, 1, 1, 1, 1, 1, 2};
   int udiv_tab [4] = '{0, 8, 0, 0};
   int ucam_tab [4] = '{0, 'h10, 'h13, 'h1F};
   int usb_tab [4] = '{1, 2, 1, 1};
   int camg_tab [4] = '{1, 2, 8, 32};
   int slow_tab [4] = '{'h34, 'h31, 'h37, 'h30};
   int fast_tab [4] = '{8, 2, 14, 1};

   // short settle and lock counts keep the run brief
   cgdc_top #(.SETTLE_CYCLES(20), .USB_LOCK_CYCLES(20)) u_dut (
      .mclk(mclk),
      .reset_n(reset_n),
      .bus_req(bus_req),
      .rdata(rdata),
      .source(source),
      .clocks(clocks),
      .gated_clk_en(gated_clk_en),
      .main_pll_power_down(main_pll_power_down),
      .usb_pll_power_down(usb_pll_power_down),
      .sleep_request(sleep_request),
      .idle_request(idle_request),
      .cpu_idle_ack(cpu_idle_ack),
      .idle_active(idle_active)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic conclude();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic reg_write(input logic [31:0] addr, input logic [31:0] data);
      @(posedge mclk);
      bus_req.wr <= 1'b1;
      bus_req.addr <= addr;
      bus_req.wdata <= data;
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [31:0] addr, output logic [31:0] data);
      @(posedge mclk);
      bus_req.rd <= 1'b1;
      bus_req.addr <= addr;
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1 data = rdata;
   endtask

   task automatic check_reg(input logic [31:0] addr, input logic [31:0] exp, input string what);
      reg_read(addr, rd_val);
      compare(rd_val, exp, what);
   endtask

   // gap between the 2nd and 3rd pulse; the first one marks the wrap where a new ratio lands
   task automatic pulse_gap(input int sel, output int g);
      int n;
      int edges;
      g = 0;
      n = 0;
      edges = 0;
      for (int i = 0; i < 200 && edges < 3; i++) begin
         @(posedge mclk);
         #1 n++;
         if (clocks[sel] === 1'b1) begin
            edges++;
            g = n;
            n = 0;
         end
      end
      if (edges < 3) g = 0;
   endtask

   task automatic expect_gap(input int sel, input int exp, input string what);
      pulse_gap(sel, gap);
      compare(gap, exp, what);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   initial begin
      #300000;
      fails++;
      conclude();
   end

   initial begin
      reset_n = 1'b0;
      bus_req = '0;
      source = '1;
      cpu_idle_ack = 1'b0;
      fails = 0;
      total_checks = 0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      check_reg(CGDC_GATE_ADDR, 32'h001FFFF0, "gate reset");
      check_reg(CGDC_SLOW_ADDR, 32'h00000004, "slow reset");
      check_reg(CGDC_DIV_ADDR, 32'h0, "divider reset");
      check_reg(CGDC_CAM_ADDR, 32'h0, "camera reset");
      reg_write(32'h4C000020, 32'hFFFFFFFF);
      check_reg(32'h4C000020, 32'h0, "unmapped read");
      reg_write(CGDC_DIV_ADDR, 32'hFFFFFFFF);
      check_reg(CGDC_DIV_ADDR, 32'h0000000F, "divider mask");
      reg_write(CGDC_CAM_ADDR, 32'hFFFFFFFF);
      check_reg(CGDC_CAM_ADDR, 32'h0000131F, "camera mask");
      reg_write(CGDC_DIV_ADDR, 32'h0);
      reg_write(CGDC_CAM_ADDR, 32'h0);
      $display("registers test done");
      for (int k = 0; k < 2; k++) begin
         reg_write(CGDC_GATE_ADDR, pat[k]);
         settle(3);
         seen = '0;
         repeat (12) begin
            @(posedge mclk);
            #1 seen = seen | gated_clk_en;
         end
         compare({15'h0, seen}, {15'h0, pat[k][20:4]}, "gated pulses");
         pulse_gap(RTC, gap);
         compare({31'h0, gap > 0}, 32'h1, "timekeeping runs");
      end
      $display("gating test done");
      reg_write(CGDC_GATE_ADDR, 32'h001FFFF8);
      settle(2);
      compare(sleep_request, 1'b1, "sleep request");
      reg_write(CGDC_GATE_ADDR, 32'h001FFFF0);
      @(posedge mclk);
      cpu_idle_ack <= 1'b1;
      settle(4);
      compare({sleep_request, idle_active}, 2'b00, "ack without request");
      reg_write(CGDC_GATE_ADDR, 32'h001FFFF4);
      settle(3);
      compare(idle_active, 1'b1, "idle entered");
      @(posedge mclk);
      cpu_idle_ack <= 1'b0;
      settle(20);
      compare({idle_request, idle_active}, 2'b11, "idle holds");
      check_reg(CGDC_STAT_ADDR, 32'h0000000E, "idle status");
      reg_write(CGDC_GATE_ADDR, 32'h001FFFF0);
      settle(3);
      compare({idle_request, idle_active}, 2'b00, "idle cleared");
      $display("power request test done");
      for (int i = 0; i < 7; i++) begin
         reg_write(CGDC_DIV_ADDR, div_tab[i]);
         reg_write(CGDC_CAM_ADDR, cam_tab[i]);
         expect_gap(BUS, bus_tab[i], "bus ratio");
         expect_gap(PER, per_tab[i], "peripheral ratio");
         expect_gap(CORE, core_tab[i], "core ratio");
      end
      for (int i = 0; i < 4; i++) begin
         reg_write(CGDC_DIV_ADDR, udiv_tab[i]);
         reg_write(CGDC_CAM_ADDR, ucam_tab[i]);
         expect_gap(USB, usb_tab[i], "usb ratio");
         expect_gap(CAM, camg_tab[i], "camera ratio");
      end
      $display("divider test done");
      reg_write(CGDC_SLOW_ADDR, 32'h00000024);
      settle(3);
      compare(main_pll_power_down, 1'b0, "pll kept up");
      expect_gap(FAST, 1, "fast from pll");
      for (int i = 0; i < 4; i++) begin
         reg_write(CGDC_SLOW_ADDR, slow_tab[i]);
         settle(3);
         compare(main_pll_power_down, 1'b1, "pll down in slow");
         expect_gap(FAST, fast_tab[i], "slow ratio");
      end
      reg_write(CGDC_SLOW_ADDR, 32'h00000010);
      // software waits past the settle time before leaving slow mode
      settle(25);
      check_reg(CGDC_STAT_ADDR, 32'h00000006, "pll settled");
      reg_write(CGDC_SLOW_ADDR, 32'h00000000);
      expect_gap(FAST, 1, "back on pll");
      $display("slow mode test done");
      reg_write(CGDC_SLOW_ADDR, 32'h00000080);
      settle(3);
      compare(usb_pll_power_down, 1'b1, "usb pll off");
      expect_gap(USB, 0, "usb clock stopped");
      reg_write(CGDC_SLOW_ADDR, 32'h00000000);
      settle(5);
      compare({usb_pll_power_down, clocks.usb_clock}, 2'b00, "usb lock wait");
      expect_gap(USB, 1, "usb clock back");
      $display("usb test done");
      conclude();
   end
endmodule
`default_nettype wire
